/* rtl/aiss_top.sv */
// aiss_top: channel scan sequencer and measurement pipeline with an
// Avalon-MM register slave and a level interrupt.
// assumes: converter, terminal-detect and slot pins are asynchronous and
// are synchronised here; the converter holds its data while done is high.
//
// Function
// RULE1 - eight or sixteen channels share one converter
// RULE2 - six selectable ranges per channel
// RULE3 - gain from range type, drift compensated
// RULE4 - one channel at a time through multiplexer
// RULE5 - correct, filter, then scale each conversion
// RULE6 - normal or fast mode; normal length fixed
// RULE7 - fast mode visits only in-use channels
// RULE8 - normal cycle 27 ms or 51 ms
// RULE9 - fast cycle lasts (N+1) times 3 ms
// RULE10 - reference acquisition in every cycle
// RULE11 - filter bypassed in fast mode
// RULE12 - free-running cycle, latest values always readable
// RULE13 - processor samples values, accepts repeats
// RULE14 - configuration accepted over slot-addressed rack bus
// RULE15 - values and module status sent to application
// RULE16 - self-monitoring faults reported to application
// RULE17 - fast: in-use slots ascending, then reference
// RULE18 - normal: all channels ascending, then reference
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module aiss_top
	import aiss_pkg::*;
#(
	parameter int NUM_CH        = 8,
	parameter int SLOT_CYCLES   = SLOT_CYC,
	parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
	input  wire logic               sys_clk_i,
	input  wire logic               rst_i,
	input  wire logic [7:0]         avs_address_i,
	input  wire logic               avs_read_i,
	input  wire logic               avs_write_i,
	input  wire logic [31:0]        avs_writedata_i,
	input  wire logic [3:0]         avs_byteenable_i,
	output logic [31:0]             avs_readdata_o,
	output logic                    avs_waitrequest_o,
	input  wire logic [3:0]         slot_addr_i,
	input  wire logic [ADC_W-1:0]   adc_data_i,
	input  wire logic               adc_done_i,
	input  wire logic               term_present_i,
	output aiss_conv_type           conv_o,
	output logic                    irq_o
);

// ----------------------------------------------------------------------
// local constants
// ----------------------------------------------------------------------
localparam int NORMAL_SLOTS = (NUM_CH > 8) ? NORMAL_SLOTS16 : NORMAL_SLOTS8;
localparam int LAST_CH      = NORMAL_SLOTS - 2;
localparam logic [19:0] SLOT_LAST   = 20'(SLOT_CYCLES - 1);
localparam logic [19:0] SETTLE_LAST = 20'(SETTLE_CYCLES - 1);

// ----------------------------------------------------------------------
// declarations
// ----------------------------------------------------------------------
logic [ADC_W-1:0]          adc_s1_ff, adc_s2_ff;
logic                      done_s1_ff, done_s2_ff, done_s3_ff;
logic                      term_s1_ff, term_s2_ff;
logic [3:0]                slot_s1_ff, slot_s2_ff;
logic                      done_evt;
logic                      ack_ff, req, wr_en;
logic [31:0]               rdata_ff, rd_mux, wval;
aiss_cfg_type              cfg_ff;
logic [NCH_MAX-1:0]        inuse_ff, ovf_ff, seeded_ff;
logic [23:0]               range_lo_ff, range_hi_ff;
logic [47:0]               ranges;
logic signed [15:0]        align_ff;
logic [15:0]               recal_ff;
logic [EV_W-1:0]           evt_ff, en_ff, evt_set, evt_clr;
logic                      irq_ff;
aiss_state_type            state_ff;
logic [19:0]               timer_ff;
logic [CH_W-1:0]           cur_ch_ff, pa_ch_ff;
logic                      ref_slot_ff, fast_cyc_ff, slot_end, cap;
logic [CH_W:0]             first_pick, next_pick;
aiss_conv_type             conv_ff;
logic signed [12:0]        selfcal_ff, ref_diff;
logic signed [17:0]        corr_ff, corr_sum, corr_next;
logic signed [34:0]        corr_prod;
logic                      pa_valid_ff, conv_fault;
logic signed [25:0]        filt_ff [NCH_MAX];
logic signed [VAL_W-1:0]   value_ff [NCH_MAX];
logic signed [25:0]        f_in, f_old, f_new;
logic signed [26:0]        f_diff;
logic                      f_bypass, ovf_now;
aiss_scale_type            sc;
logic signed [18:0]        sc_off;
logic signed [34:0]        sc_prod;
logic signed [22:0]        sc_full;
logic signed [VAL_W-1:0]   sc_sat;

// byte-lane merge for partial writes
function automatic logic [31:0] be_merge(input logic [31:0] old,
	input logic [31:0] nw, input logic [3:0] be);
	logic [31:0] r;
	r = old;
	for (int b = 0; b < 4; b++)
		if (be[b])
			r[b*8 +: 8] = nw[b*8 +: 8];
	return r;
endfunction

// lowest eligible channel at or above from; top bit flags a hit
function automatic logic [CH_W:0] pick_ch(input logic [NCH_MAX-1:0] mask,
	input int from, input logic fast);
	logic [CH_W:0] r;
	r = '0;
	for (int i = NCH_MAX - 1; i >= 0; i--)
		if (i >= from && (fast ? (i < NUM_CH && mask[i]) : i <= LAST_CH))
			r = {1'b1, CH_W'(i)};
	return r;
endfunction

// ----------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------
// every pin passes two flops; done also gets a third for edge detect
always_ff @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		adc_s1_ff  <= '0;
		adc_s2_ff  <= '0;
		done_s1_ff <= 1'b0;
		done_s2_ff <= 1'b0;
		done_s3_ff <= 1'b0;
		term_s1_ff <= 1'b1; // reset as present: no false fault
		term_s2_ff <= 1'b1;
		slot_s1_ff <= '0;
		slot_s2_ff <= '0;
	end
	else
	begin
		adc_s1_ff  <= adc_data_i;
		adc_s2_ff  <= adc_s1_ff;
		done_s1_ff <= adc_done_i;
		done_s2_ff <= done_s1_ff;
		done_s3_ff <= done_s2_ff;
		term_s1_ff <= term_present_i;
		term_s2_ff <= term_s1_ff;
		slot_s1_ff <= slot_addr_i;
		slot_s2_ff <= slot_s1_ff;
	end
end

assign done_evt = done_s2_ff & ~done_s3_ff;

// ----------------------------------------------------------------------
// register bus slave
// ----------------------------------------------------------------------
// one wait state: readdata is registered so the bus never sees a long path
assign req               = avs_read_i | avs_write_i;
assign avs_waitrequest_o = req & ~ack_ff;
assign wr_en             = avs_write_i & ack_ff;
assign avs_readdata_o    = rdata_ff;
assign wval              = be_merge(rd_mux, avs_writedata_i, avs_byteenable_i);
assign ranges            = {range_hi_ff, range_lo_ff};

always_ff @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		ack_ff   <= 1'b0;
		rdata_ff <= '0;
	end
	else
	begin
		ack_ff <= req & ~ack_ff;
		if (avs_read_i & ~ack_ff)
			rdata_ff <= rd_mux;
	end
end

// read decode; unmapped offsets read as zero
always_comb
begin
	rd_mux = '0;
	case (avs_address_i)
		REG_CTRL:       rd_mux = 32'(cfg_ff);
		REG_INUSE:      rd_mux = 32'(inuse_ff);
		REG_RANGE_LO:   rd_mux = 32'(range_lo_ff);
		REG_RANGE_HI:   rd_mux = 32'(range_hi_ff);
		REG_EVT_STATUS: rd_mux = 32'(evt_ff);
		REG_EVT_ENABLE: rd_mux = 32'(en_ff);
		REG_ALIGN:      rd_mux = 32'($unsigned(align_ff));
		REG_RECAL:      rd_mux = 32'(recal_ff);
		REG_OVF:        rd_mux = 32'(ovf_ff);
		REG_SELFCAL:    rd_mux = 32'($unsigned(selfcal_ff));
		REG_MOD_STATUS:
		begin
			rd_mux[MST_CH_LSB +: CH_W]   = cur_ch_ff;
			rd_mux[MST_BUSY_BIT]         = (state_ff != ST_IDLE);
			rd_mux[MST_REF_BIT]          = ref_slot_ff;
			rd_mux[MST_FAST_BIT]         = fast_cyc_ff;
			rd_mux[MST_TERM_BIT]         = term_s2_ff;
			rd_mux[MST_SLOT_LSB +: 4]    = slot_s2_ff; // [RULE14]
		end
		default:
			// latest value of each channel, any time [RULE12] [RULE15]
			if (avs_address_i[7:6] == VALUE_PAGE &&
				avs_address_i[1:0] == 2'h0 &&
				int'(avs_address_i[5:2]) < NUM_CH)
				rd_mux = 32'($unsigned(value_ff[avs_address_i[5:2]]));
	endcase
end

// software configuration [RULE14]
always_ff @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		cfg_ff      <= CTRL_RST;
		inuse_ff    <= INUSE_RST;
		range_lo_ff <= '0;
		range_hi_ff <= '0;
		align_ff    <= $signed(ALIGN_RST);
		recal_ff    <= RECAL_RST;
		en_ff       <= '0;
	end
	else if (wr_en)
	begin
		case (avs_address_i)
			REG_CTRL:       cfg_ff      <= aiss_cfg_type'(wval[CTRL_W-1:0]);
			REG_INUSE:      inuse_ff    <= wval[NCH_MAX-1:0];
			REG_RANGE_LO:   range_lo_ff <= wval[23:0]; // [RULE2]
			REG_RANGE_HI:   range_hi_ff <= wval[23:0]; // [RULE2]
			REG_ALIGN:      align_ff    <= $signed(wval[15:0]);
			REG_RECAL:      recal_ff    <= wval[15:0];
			REG_EVT_ENABLE: en_ff       <= wval[EV_W-1:0];
			default:        en_ff       <= en_ff;
		endcase
	end
end

// ----------------------------------------------------------------------
// events and interrupt
// ----------------------------------------------------------------------
assign evt_clr = (wr_en && avs_address_i == REG_EVT_CLEAR) ?
	wval[EV_W-1:0] : '0;

// self-monitoring faults and cycle completion [RULE16]
always_comb
begin
	evt_set           = '0;
	evt_set[EV_CYCLE] = slot_end & ref_slot_ff & (state_ff != ST_IDLE);
	evt_set[EV_OVF]   = pa_valid_ff & ovf_now;
	evt_set[EV_CONV]  = conv_fault;
	evt_set[EV_TERM]  = ~term_s2_ff;
	evt_set[EV_WDOG]  = slot_end & (state_ff != ST_IDLE) &
		(state_ff != ST_HOLD);
end

// a set in the clearing cycle wins, so no event is lost
always_ff @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		evt_ff <= '0;
		irq_ff <= 1'b0;
	end
	else
	begin
		evt_ff <= (evt_ff & ~evt_clr) | evt_set; // [RULE16]
		irq_ff <= |(evt_ff & en_ff);
	end
end

assign irq_o = irq_ff;

// ----------------------------------------------------------------------
// scan sequencer
// ----------------------------------------------------------------------
assign slot_end   = (state_ff != ST_IDLE) && (timer_ff == SLOT_LAST);
assign first_pick = pick_ch(inuse_ff, 0, cfg_ff.fast); // [RULE17] [RULE18]
assign next_pick  = pick_ch(inuse_ff, int'(cur_ch_ff) + 1, fast_cyc_ff);
assign cap        = (state_ff == ST_CONV) & done_evt & ~slot_end;

// every slot lasts the channel slot time, so a normal cycle always has
// NORMAL_SLOTS slots and a fast cycle one per in-use channel plus one;
// the mode is latched per cycle so a change never bends a running cycle
always_ff @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		state_ff    <= ST_IDLE;
		timer_ff    <= '0;
		cur_ch_ff   <= '0;
		ref_slot_ff <= 1'b0;
		fast_cyc_ff <= 1'b0;
	end
	else if (state_ff == ST_IDLE || (slot_end && ref_slot_ff))
	begin
		// free-running restart, no sync to the processor [RULE12]
		timer_ff <= '0;
		if (cfg_ff.run)
		begin
			state_ff    <= ST_SETTLE;
			fast_cyc_ff <= cfg_ff.fast; // [RULE6]
			cur_ch_ff   <= first_pick[CH_W-1:0];
			ref_slot_ff <= ~first_pick[CH_W]; // [RULE7] [RULE9]
		end
		else
			state_ff <= ST_IDLE;
	end
	else if (slot_end)
	begin
		timer_ff <= '0;
		state_ff <= ST_SETTLE;
		if (next_pick[CH_W])
			cur_ch_ff <= next_pick[CH_W-1:0]; // [RULE7] [RULE18]
		else
			ref_slot_ff <= 1'b1; // [RULE10] [RULE8] [RULE9]
	end
	else
	begin
		timer_ff <= timer_ff + 20'h00001;
		case (state_ff)
			ST_SETTLE:
				if (timer_ff == SETTLE_LAST)
					state_ff <= ST_CONV;
			ST_CONV:
				if (done_evt)
					state_ff <= ST_HOLD;
			default:
				state_ff <= state_ff;
		endcase
	end
end

// mux, gain and start pins; the reference slot uses the bipolar gain
always_ff @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
		conv_ff <= '0;
	else
	begin
		conv_ff.mux     <= cur_ch_ff; // [RULE4] [RULE1]
		conv_ff.ref_sel <= ref_slot_ff; // [RULE10]
		conv_ff.gain    <= ref_slot_ff ? GAIN_BIP :
			range_scale(aiss_range_type'(ranges[cur_ch_ff*RANGE_W +:
			RANGE_W])).gain; // [RULE3]
		conv_ff.start   <= (state_ff == ST_SETTLE) &&
			(timer_ff == SETTLE_LAST) && !slot_end;
	end
end

assign conv_o = conv_ff;

// ----------------------------------------------------------------------
// correction stage
// ----------------------------------------------------------------------
// reference offset doubles as drift compensation for the amplifier
assign ref_diff   = $signed({1'b0, adc_s2_ff}) - $signed({1'b0, REF_NOMINAL});
assign conv_fault = cap & ref_slot_ff & ((ref_diff > REF_TOL) ||
	(ref_diff < -REF_TOL));
assign corr_sum   = $signed({6'h00, adc_s2_ff}) - 18'(selfcal_ff) +
	18'(align_ff);
assign corr_prod  = corr_sum * $signed({1'b0, recal_ff});
assign corr_next  = corr_prod[RECAL_SHIFT +: 18]; // [RULE5] [RULE3]

always_ff @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		pa_valid_ff <= 1'b0;
		pa_ch_ff    <= '0;
		corr_ff     <= '0;
		selfcal_ff  <= '0;
	end
	else
	begin
		pa_valid_ff <= cap & ~ref_slot_ff;
		if (cap & ref_slot_ff)
			selfcal_ff <= ref_diff; // [RULE10]
		if (cap)
		begin
			pa_ch_ff <= cur_ch_ff;
			corr_ff  <= corr_next;
		end
	end
end

// ----------------------------------------------------------------------
// filter and scaling stage
// ----------------------------------------------------------------------
// first-order filter, alpha = 1 - 2^-(filt+1); first sample seeds it
always_comb
begin
	f_in     = {corr_ff, 8'h00};
	f_old    = filt_ff[pa_ch_ff];
	f_bypass = fast_cyc_ff || cfg_ff.filt == 3'h0 ||
		!seeded_ff[pa_ch_ff]; // [RULE11]
	f_diff   = 27'(f_in) - 27'(f_old);
	f_new    = f_bypass ? f_in :
		f_old + 26'(f_diff >>> (4'(cfg_ff.filt) + 4'h1)); // [RULE5]
	sc       = range_scale(aiss_range_type'(ranges[pa_ch_ff*RANGE_W +:
		RANGE_W]));
	sc_off   = 19'($signed(f_new[25:FRAC_W])) - 19'(sc.zero);
	sc_prod  = sc_off * sc.mult;
	sc_full  = sc_prod[34:12]; // [RULE5]
	ovf_now  = (sc_full < 23'(sc.lo)) || (sc_full > 23'(sc.hi));
	if (sc_full > 23'sh007FFF)
		sc_sat = 16'sh7FFF;
	else if (sc_full < -23'sh008000)
		sc_sat = -16'sh8000;
	else
		sc_sat = sc_full[VAL_W-1:0];
end

// results land per channel; the processor may see repeats [RULE13]
always_ff @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		seeded_ff <= '0;
		ovf_ff    <= '0;
		for (int i = 0; i < NCH_MAX; i++)
		begin
			filt_ff[i]  <= '0;
			value_ff[i] <= '0;
		end
	end
	else if (pa_valid_ff)
	begin
		filt_ff[pa_ch_ff]   <= f_new;
		seeded_ff[pa_ch_ff] <= 1'b1;
		value_ff[pa_ch_ff]  <= sc_sat; // [RULE15]
		ovf_ff[pa_ch_ff]    <= ovf_now; // [RULE16]
	end
end

endmodule

`default_nettype wire

/* include/aiss_pkg.sv */
// aiss_pkg: register map, field layout, timing counts and carrier types
// for the analog input scan sequencer.
// assumes: one 250 MHz clock domain and a 32-bit Avalon-MM register bus.
package aiss_pkg;

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
localparam int NCH_MAX = 16;
localparam int CH_W    = 4;
localparam int ADC_W   = 12;
localparam int VAL_W   = 16;
localparam int FRAC_W  = 8;
localparam int RANGE_W = 3;

// ----------------------------------------------------------------------
// register map (byte offsets) and fields
// ----------------------------------------------------------------------
localparam logic [7:0] REG_CTRL       = 8'h00;
localparam logic [7:0] REG_INUSE      = 8'h04;
localparam logic [7:0] REG_RANGE_LO   = 8'h08;
localparam logic [7:0] REG_RANGE_HI   = 8'h0C;
localparam logic [7:0] REG_EVT_STATUS = 8'h10;
localparam logic [7:0] REG_EVT_CLEAR  = 8'h14;
localparam logic [7:0] REG_EVT_ENABLE = 8'h18;
localparam logic [7:0] REG_MOD_STATUS = 8'h1C;
localparam logic [7:0] REG_ALIGN      = 8'h20;
localparam logic [7:0] REG_RECAL      = 8'h24;
localparam logic [7:0] REG_OVF        = 8'h28;
localparam logic [7:0] REG_SELFCAL    = 8'h2C;
localparam logic [1:0] VALUE_PAGE     = 2'h1;

localparam int CTRL_W         = 5;
localparam int MST_CH_LSB     = 0;
localparam int MST_BUSY_BIT   = 4;
localparam int MST_REF_BIT    = 5;
localparam int MST_FAST_BIT   = 6;
localparam int MST_TERM_BIT   = 7;
localparam int MST_SLOT_LSB   = 8;

localparam int EV_CYCLE = 0;
localparam int EV_OVF   = 1;
localparam int EV_CONV  = 2;
localparam int EV_TERM  = 3;
localparam int EV_WDOG  = 4;
localparam int EV_W     = 5;

localparam logic [CTRL_W-1:0]  CTRL_RST  = 5'h00;
localparam logic [NCH_MAX-1:0] INUSE_RST = 16'hFFFF;
localparam logic [15:0]        RECAL_RST = 16'h8000;
localparam logic [15:0]        ALIGN_RST = 16'h0000;
localparam int                 RECAL_SHIFT = 15;

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
localparam int CLK_MHZ         = 250;
localparam int SLOT_TIME_US    = 3000;
localparam int SLOT_CYC        = SLOT_TIME_US * CLK_MHZ;
localparam int SETTLE_TIME_NS  = 10000;
localparam int SETTLE_CYC      = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
localparam int CYCLE8_MS       = 27;
localparam int CYCLE16_MS      = 51;
localparam int NORMAL_SLOTS8   = CYCLE8_MS * 1000 / SLOT_TIME_US;
localparam int NORMAL_SLOTS16  = CYCLE16_MS * 1000 / SLOT_TIME_US;

// reference acquisition window
localparam logic [ADC_W-1:0]  REF_NOMINAL = 12'h800;
localparam logic signed [12:0] REF_TOL    = 13'sh0100;

// ----------------------------------------------------------------------
// types
// ----------------------------------------------------------------------
typedef enum logic [2:0] {
	RNG_BIP10, RNG_UNI10, RNG_UNI5, RNG_1TO5, RNG_0TO20MA, RNG_4TO20MA
} aiss_range_type;

typedef enum logic [1:0] {
	GAIN_BIP, GAIN_UNI10, GAIN_UNI5, GAIN_CUR
} aiss_gain_type;

typedef enum {ST_IDLE, ST_SETTLE, ST_CONV, ST_HOLD} aiss_state_type;

typedef struct packed {
	logic                start;
	logic                ref_sel;
	aiss_gain_type       gain;
	logic [CH_W-1:0]     mux;
} aiss_conv_type;

typedef struct packed {
	logic                run;
	logic                fast;
	logic [2:0]          filt;
} aiss_cfg_type;

typedef struct packed {
	logic signed [12:0]  zero;
	logic signed [15:0]  mult;
	logic signed [15:0]  lo;
	logic signed [15:0]  hi;
	aiss_gain_type       gain;
} aiss_scale_type;

// per-range zero code, scale (x4096), limits and amplifier gain
function automatic aiss_scale_type range_scale(input aiss_range_type r);
	case (r)
		RNG_UNI10:   return '{13'sh0000, 16'sh2712, -16'sh01F4, 16'sh2904,
		                      GAIN_UNI10};
		RNG_UNI5:    return '{13'sh0000, 16'sh2712, -16'sh01F4, 16'sh2904,
		                      GAIN_UNI5};
		RNG_1TO5:    return '{13'sh0333, 16'sh30D7, -16'sh01F4, 16'sh2904,
		                      GAIN_UNI5};
		RNG_0TO20MA: return '{13'sh0000, 16'sh2712, 16'sh0000, 16'sh2904,
		                      GAIN_CUR};
		RNG_4TO20MA: return '{13'sh0333, 16'sh30D7, -16'sh01F4, 16'sh2904,
		                      GAIN_CUR};
		default:     return '{13'sh0800, 16'sh4E20, -16'sh2904, 16'sh2904,
		                      GAIN_BIP};
	endcase
endfunction

endpackage

/* sim/aiss_adc_model.sv */
// aiss_adc_model: behavioural converter on the far side of conv_o.
// assumes: one clock; done is a level that the bench may delay or mute.
`timescale 1ns/10ps
`default_nettype none

module aiss_adc_model
	import aiss_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire aiss_conv_type    conv_i,
	input  wire logic             mute_i,
	input  wire logic [3:0]       lag_i,
	input  wire logic [ADC_W-1:0] code_i,
	output logic                  done_o,
	output logic [ADC_W-1:0]      data_o
);
	logic [4:0] cnt_ff;
	logic [2:0] hld_ff;

	// answer after lag; data stand while done is high, then go inverted
	// so a late sample by the sequencer cannot pass for a good one
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_ff <= 5'h00;
			hld_ff <= 3'h0;
			done_o <= 1'b0;
			data_o <= 12'h000;
		end
		else
		begin
			if (conv_i.start && !mute_i)
				cnt_ff <= {1'b0, lag_i} + 5'h01;
			else if (cnt_ff != 5'h00)
				cnt_ff <= cnt_ff - 5'h01;
			if (cnt_ff == 5'h01)
			begin
				done_o <= 1'b1;
				data_o <= conv_i.ref_sel ? REF_NOMINAL : code_i;
				hld_ff <= 3'h4;
			end
			else if (hld_ff != 3'h0)
				hld_ff <= hld_ff - 3'h1;
			else if (done_o)
			begin
				done_o <= 1'b0;
				data_o <= ~data_o;
			end
		end
	end
endmodule

`default_nettype wire

/* sim/aiss_top_asserts.sv */
// aiss_top_asserts: port-level checks of bus handshake and scan order.
// assumes: bound to aiss_top; run is never cleared once set.
`timescale 1ns/10ps
`default_nettype none

module aiss_top_asserts
	import aiss_pkg::*;
#(
	parameter int NUM_CH      = 8,
	parameter int SLOT_CYCLES = 200
)
(
	input  wire logic          sys_clk_i,
	input  wire logic          rst_i,
	input  wire logic          avs_read_i,
	input  wire logic          avs_write_i,
	input  wire logic          avs_waitrequest_o,
	input  wire aiss_conv_type conv_o,
	input  wire logic          irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	logic [31:0] gap_ff;
	logic        seen_ff;
	logic        pref_ff;
	logic [3:0]  pmux_ff;
	logic [4:0]  nch_ff;

	// cycles since last start, last slot kind and channels since reference
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			gap_ff  <= '0;
			seen_ff <= 1'b0;
			pref_ff <= 1'b1;
			pmux_ff <= 4'h0;
			nch_ff  <= 5'h00;
		end
		else if (conv_o.start)
		begin
			gap_ff  <= '0;
			seen_ff <= 1'b1;
			pref_ff <= conv_o.ref_sel;
			pmux_ff <= conv_o.mux;
			nch_ff  <= conv_o.ref_sel ? 5'h00 : nch_ff + 5'h01;
		end
		else
			gap_ff <= gap_ff + 32'h1;
	end

	wait_one_a: assert property ((avs_read_i || avs_write_i)
		&& avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
	wait_idle_a: assert property (!(avs_read_i || avs_write_i)
		|-> !avs_waitrequest_o) else $error("idle wait");
	start_pulse_a: assert property (conv_o.start |=> !conv_o.start)
		else $error("start too long");
	slot_hold_a: assert property (conv_o.start
		|-> $stable({conv_o.mux, conv_o.gain, conv_o.ref_sel}))
		else $error("mux moved");
	slot_len_a: assert property (conv_o.start && seen_ff
		|-> gap_ff == SLOT_CYCLES - 1) else $error("slot length");
	scan_order_a: assert property (conv_o.start && !conv_o.ref_sel
		&& !pref_ff |-> conv_o.mux > pmux_ff) else $error("order");
	ref_cycle_a: assert property (conv_o.start && !conv_o.ref_sel
		|-> nch_ff < NUM_CH) else $error("no reference");
	mux_range_a: assert property (conv_o.start && !conv_o.ref_sel
		|-> conv_o.mux < NUM_CH) else $error("bad channel");

	ref_c: cover property (conv_o.start && conv_o.ref_sel);
	last_c: cover property (conv_o.start && conv_o.mux == NUM_CH - 1);
	irq_c: cover property ($rose(irq_o));
endmodule

bind aiss_top aiss_top_asserts #(
	.NUM_CH      (NUM_CH),
	.SLOT_CYCLES (SLOT_CYCLES)
) u_aiss_top_asserts (
	.sys_clk_i         (sys_clk_i),
	.rst_i             (rst_i),
	.avs_read_i        (avs_read_i),
	.avs_write_i       (avs_write_i),
	.avs_waitrequest_o (avs_waitrequest_o),
	.conv_o            (conv_o),
	.irq_o             (irq_o)
);

`default_nettype wire

/* sim/analog_input_scan_sequencer_tb_top.sv */
// analog_input_scan_sequencer_tb_top: self-checking bench for aiss_top.
// assumes: short slot counts; the converter model answers every start except while the bench holds mute high.
`timescale 1ns/10ps
`default_nettype none

module analog_input_scan_sequencer_tb_top
	import aiss_pkg::*;
;
	typedef struct packed {
		logic        we;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} aiss_row_type;
	localparam int SLOT = 200;

	logic             sys_clk = 1'b0;
	logic             rst     = 1'b1;
	logic             rd      = 1'b0;
	logic             wr      = 1'b0;
	logic             mute    = 1'b0;
	logic             term    = 1'b1;
	logic [7:0]       adr     = 8'h00;
	logic [31:0]      wd      = 32'h0;
	logic [3:0]       lag     = 4'h0;
	logic [ADC_W-1:0] code    = 12'hC00;
	logic [31:0]      rdata;
	logic [31:0]      q;
	logic             wreq;
	logic             irq;
	logic             done;
	logic [ADC_W-1:0] adc;
	aiss_conv_type    conv;
	int               err_count = 0;
	int               checks = 0;
	aiss_row_type     rows [12] = '{
		'{0, REG_CTRL, 0, 0}, '{0, REG_INUSE, 0, 32'hFFFF},
		'{0, REG_RECAL, 0, 32'h8000}, '{0, REG_ALIGN, 0, 0},
		'{1, 8'h30, 32'hFFFFFFFF, 0}, '{0, 8'h30, 0, 0},
		'{0, REG_EVT_CLEAR, 0, 0}, '{1, REG_EVT_ENABLE, 32'h1F, 0},
		'{0, REG_EVT_ENABLE, 0, 32'h1F}, '{1, REG_OVF, 32'hFFFF, 0},
		'{0, REG_OVF, 0, 0}, '{0, REG_RANGE_LO, 0, 0}};

	always #2 sys_clk = ~sys_clk;

	aiss_top #(.NUM_CH(8), .SLOT_CYCLES(SLOT), .SETTLE_CYCLES(20)) u_aiss_top (
		.sys_clk_i(sys_clk), .rst_i(rst), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .slot_addr_i(4'hA), .adc_data_i(adc),
		.adc_done_i(done), .term_present_i(term), .conv_o(conv),
		.irq_o(irq));

	aiss_adc_model u_aiss_adc_model (
		.clk_i(sys_clk), .rst_i(rst), .conv_i(conv), .mute_i(mute),
		.lag_i(lag), .code_i(code), .done_o(done), .data_o(adc));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// hold the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge sys_clk);
		rd <= !we;
		wr <= we;
		adr <= a;
		wd <= d;
		@(posedge sys_clk);
		while (wreq !== 1'b0)
			@(posedge sys_clk);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// time between two cycle-done interrupts, in clock cycles
	task automatic measure(input logic [31:0] exp);
		time t0;
		bus(1, REG_EVT_CLEAR, 32'h1F, q);
		@(posedge irq);
		bus(1, REG_EVT_CLEAR, 32'h1F, q);
		@(posedge irq);
		t0 = $time;
		bus(1, REG_EVT_CLEAR, 32'h1F, q);
		@(posedge irq);
		chk(32'(($time - t0) / 4), exp);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// a hung handshake or a missing interrupt ends here
	initial
	begin
		#(4 * 40000);
		err_count++;
		end_sim;
	end

	initial
	begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (rows[i])
		begin
			bus(rows[i].we, rows[i].a, rows[i].d, q);
			if (!rows[i].we) chk(q, rows[i].e);
		end
		bus(0, REG_MOD_STATUS, 0, q);
		chk(32'(q[11:7]), 32'h15);
		$display("test registers done");
		bus(1, REG_CTRL, 32'h10, q);
		measure(9 * SLOT);
		repeat (2)
		begin
			bus(0, 8'h40, 0, q);
			chk(q, 32'h1388);
		end
		$display("test normal cycle done");
		// slow converter, filter on but bypassed, negative reading
		lag <= 4'hF;
		code <= 12'h400;
		bus(1, REG_INUSE, 32'h68, q);
		bus(1, REG_CTRL, 32'h1F, q);
		measure(4 * SLOT);
		bus(0, 8'h4C, 0, q);
		chk(q, 32'hEC78);
		bus(1, REG_INUSE, 32'h0, q);
		measure(SLOT);
		$display("test fast cycle done");
		bus(1, REG_EVT_ENABLE, 32'h0, q);
		repeat (2 * SLOT) @(posedge sys_clk);
		chk(32'(irq), 32'h0);
		bus(0, REG_EVT_STATUS, 0, q);
		chk(32'(q[0]), 32'h1);
		bus(1, REG_EVT_CLEAR, 32'h1, q);
		bus(0, REG_EVT_STATUS, 0, q);
		chk(32'(q[0]), 32'h0);
		$display("test interrupt mask done");
		mute <= 1'b1;
		repeat (2 * SLOT) @(posedge sys_clk);
		bus(0, REG_EVT_STATUS, 0, q);
		chk(32'(q[4]), 32'h1);
		mute <= 1'b0;
		term <= 1'b0;
		bus(1, REG_EVT_ENABLE, 32'h8, q);
		repeat (10) @(posedge sys_clk);
		bus(0, REG_EVT_STATUS, 0, q);
		chk(32'(q[3]), 32'h1);
		chk(32'(irq), 32'h1);
		term <= 1'b1;
		$display("test faults done");
		// normal cycle, filter k=1 on channel 3 seeded at 0x400
		code <= 12'hC00;
		bus(1, REG_CTRL, 32'h11, q);
		repeat (1000) @(posedge sys_clk);
		bus(0, 8'h4C, 0, q);
		chk(q, 32'hF63C);
		$display("test filter done");
		// reset in mid-run stops the sequencer and clears config
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk(32'(conv), 32'h0);
		bus(0, REG_CTRL, 0, q);
		chk(q, 32'h0);
		$display("test reset done");
		end_sim;
	end
endmodule

`default_nettype wire
